// ==== ifc_filter_cfg.sv ====
// Purpose: Rate selection, filter mode decode, undersampling average, errors
// Assumes: Sensor inputs sampled on the shared sensor time base
// Notes: Notes on behaviour below
// Notes on behaviour
// - Both sensors sample from one time base
// - Timestamp resolution is one 39 us tick
// - Illegal filter settings raise error code bits
// - Normal accel rates: eight codes, 12.5-1600 Hz
// - Normal-mode accel rate under 12.5 Hz flags error
// - Accel bandwidth 001 selects oversample by two
// - Accel bandwidth 000 selects oversample by four
// - Low power mode cycles suspend and acquire
// - Undersampled accel rates: twelve codes, 0.78-1600 Hz
// - Output is mean of 2^bandwidth samples
// - Undersampling with prefiltered data flags error
// - Motion/tap source or fifo bit select prefilter
// - Gyro only processed in normal power
// - Gyro 010 normal; eight rates 25-3200 Hz
// - Gyro rate under 25 Hz flags error
// - Gyro bandwidth 001 selects oversample by two
// - Gyro bandwidth 000 selects oversample by four
// - Free-running sensor time paces all updates
`timescale 1ns/100ps
module ifc_filter_cfg #(
  parameter int TICK_CYCLES = ifc_pkg::ST_TICK_CYC,
  parameter int DW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [DW-1:0] accel_in,
  input wire logic signed [DW-1:0] gyro_in,
  input wire logic gyro_normal_pm,
  output logic signed [DW-1:0] accel_out,
  output logic signed [DW-1:0] gyro_out,
  output logic new_sample_signal,
  output ifc_pkg::ifc_fmode_t accel_mode,
  output ifc_pkg::ifc_fmode_t gyro_mode,
  output logic accel_suspend_phase,
  output logic accel_prefilt_sel,
  output logic [ifc_pkg::ST_WIDTH-1:0] sensor_time
);
  import ifc_pkg::*;

  // Sum width and tick counter cannot serve values outside this range
  if (TICK_CYCLES < 2 || DW < 2 || DW > 24) begin : g_param_check
    $error("ifc_filter_cfg: unsupported parameter value");
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] acc_q, gyr_q, fifo_q, err_q;
  logic [ST_WIDTH-1:0] st_q, st_n;
  logic [15:0] intd_q;
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awi_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] br_q, rr_q;
  logic wr_go, aw_map, ar_map;
  logic [7:0] ari;

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign wr_go = aw_q && w_q && !bv_q;
  assign ari = s_axi_araddr[9:2];
  assign aw_map = (awi_q == IDX_ACC) || (awi_q == IDX_GYR) ||
                  (awi_q == IDX_FIFO) || (awi_q == IDX_INTD);
  assign ar_map = (ari == IDX_ACC) || (ari == IDX_GYR) || (ari == IDX_FIFO) ||
                  (ari == IDX_INTD) || (ari == IDX_ERR) || (ari == IDX_TIME);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'b00;
      awi_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awi_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        // Unmapped or read-only index answers SLVERR
        br_q <= aw_map ? 2'b00 : 2'b10;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= RST_ACC;
      gyr_q <= RST_GYR;
      fifo_q <= RST_FIFO;
      intd_q <= RST_INTD;
    end else if (wr_go) begin
      if (ws_q[0] && awi_q == IDX_ACC) begin
        acc_q <= wd_q[7:0];
      end
      if (ws_q[0] && awi_q == IDX_GYR) begin
        gyr_q <= wd_q[7:0];
      end
      if (ws_q[0] && awi_q == IDX_FIFO) begin
        fifo_q <= wd_q[7:0];
      end
      if (awi_q == IDX_INTD) begin
        if (ws_q[0]) begin
          intd_q[7:0] <= wd_q[7:0];
        end
        if (ws_q[1]) begin
          intd_q[15:8] <= wd_q[15:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rv_q <= 1'b1;
      rr_q <= ar_map ? 2'b00 : 2'b10;
      unique case (ari)
        IDX_ERR: rd_q <= {24'h00_0000, err_q};
        IDX_ACC: rd_q <= {24'h00_0000, acc_q};
        IDX_GYR: rd_q <= {24'h00_0000, gyr_q};
        IDX_FIFO: rd_q <= {24'h00_0000, fifo_q};
        IDX_INTD: rd_q <= {16'h0000, intd_q};
        IDX_TIME: rd_q <= {8'h00, st_q};
        default: rd_q <= 32'h0000_0000;
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_q <= 1'b0;
    end
  end

  chk_write_answer: assert property (wr_go |=> bv_q && !s_axi_awready)
    else $error("write not answered");

  ////////////////////////////////////////////////////////////////////////////
  // Sensor time base, shared by both sensors
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick;

  assign tick = (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  assign st_n = st_q + 1'b1;
  assign sensor_time = st_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      st_q <= '0;
    end else if (tick) begin
      div_q <= '0;
      st_q <= st_n;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  chk_time_on_tick: assert property ($changed(st_q) |-> $past(tick))
    else $error("sensor time moved off tick");

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode and error code
  logic [3:0] a_odr, g_odr;
  logic [2:0] a_bwp;
  logic [1:0] g_bwp;
  logic a_us, prefilt, a_bad, g_bad, avg_bad;
  logic [7:0] err_d;

  assign a_odr = acc_q[F_ODR_LSB +: 4];
  assign a_bwp = acc_q[F_BWP_LSB +: 3];
  assign a_us = acc_q[F_US];
  assign g_odr = gyr_q[F_ODR_LSB +: 4];
  assign g_bwp = gyr_q[F_BWP_LSB +: 2];
  // Motion or tap source, or unfiltered fifo data, picks prefiltered path
  assign prefilt = intd_q[F_MOT_SRC] || intd_q[F_TAP_SRC] ||
                   !fifo_q[F_FIFO_FILT];
  assign accel_prefilt_sel = prefilt;
  assign a_bad = a_us ? (a_odr < ACC_ODR_MIN_US || a_odr > ACC_ODR_MAX)
                      : (a_odr < ACC_ODR_MIN_NORM || a_odr > ACC_ODR_MAX ||
                         a_bwp > 3'd2);
  assign g_bad = g_odr < GYR_ODR_MIN || g_odr > GYR_ODR_MAX || g_bwp == 2'd3;
  // Averaged count 2^bwp may not exceed 1600/ODR = 2^(12 - code)
  assign avg_bad = a_us && !a_bad && ({1'b0, a_bwp} > (4'(ACC_ODR_MAX) - a_odr));

  always_comb begin
    err_d = 8'h00;
    err_d[E_ACC] = a_bad;
    err_d[E_GYR] = g_bad;
    err_d[E_PREF] = a_us && prefilt;
    err_d[E_AVG] = avg_bad;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 8'h00;
    end else begin
      err_q <= err_d;
    end
  end

  chk_acc_low_rate: assert property (!a_us && a_odr < ACC_ODR_MIN_NORM |=> err_q[E_ACC])
    else $error("low accel rate not flagged");
  chk_gyr_low_rate: assert property (g_odr < GYR_ODR_MIN |=> err_q[E_GYR])
    else $error("low gyro rate not flagged");
  chk_prefilt_conflict: assert property (a_us && prefilt |=> err_q[E_PREF])
    else $error("prefilter conflict not flagged");
  chk_avg_overrun: assert property (a_us && a_odr == 4'hc && a_bwp == 3'd1 |=>
    err_q[E_AVG])
    else $error("average overrun not flagged");
  chk_acc_legal: assert property (!a_us && a_odr == 4'h8 && a_bwp == 3'd2 |=>
    !err_q[E_ACC])
    else $error("legal accel setting flagged");

  ////////////////////////////////////////////////////////////////////////////
  // Filter modes
  always_comb begin
    if (a_us) begin
      accel_mode = FM_UNDERSAMPLE;
    end else begin
      unique case (a_bwp)
        3'd0: accel_mode = FM_OVERSAMPLE_BY_FOUR;
        3'd1: accel_mode = FM_OVERSAMPLE_BY_TWO;
        default: accel_mode = FM_NORMAL;
      endcase
    end
    unique case (g_bwp)
      2'd0: gyro_mode = FM_OVERSAMPLE_BY_FOUR;
      2'd1: gyro_mode = FM_OVERSAMPLE_BY_TWO;
      default: gyro_mode = FM_NORMAL;
    endcase
  end

  chk_gyro_modes: assert property (g_bwp == 2'd1 |-> gyro_mode == FM_OVERSAMPLE_BY_TWO)
    else $error("gyro bandwidth decode wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Rate strobes from sensor time bit toggles
  logic a_rate, g_rate, base_rate;
  int a_bit, g_bit;

  assign a_bit = ODR_BIT_BASE - int'(a_odr);
  assign g_bit = ODR_BIT_BASE - int'(g_odr);
  assign base_rate = tick && (st_q[BASE_RATE_BIT] != st_n[BASE_RATE_BIT]);
  assign a_rate = tick && !err_q[E_ACC] && a_bit >= 0 && a_bit < ST_WIDTH &&
                  (st_q[a_bit] != st_n[a_bit]);
  assign g_rate = tick && !err_q[E_GYR] && g_bit >= 0 && g_bit < ST_WIDTH &&
                  (st_q[g_bit] != st_n[g_bit]);

  ////////////////////////////////////////////////////////////////////////////
  // Accelerometer path: plain sampling or undersampled average
  logic signed [DW+6:0] sum_q;
  logic [7:0] cnt_q, avg_n;
  logic acc_upd, gyr_upd, us_ok;

  assign avg_n = 8'd1 << a_bwp;
  assign us_ok = a_us && err_q[E_PREF] == 1'b0 && !err_q[E_AVG];
  assign acc_upd = a_rate && (!a_us || us_ok);
  // Past the averaged samples the sensor sits in suspend until next period
  assign accel_suspend_phase = a_us && (cnt_q >= avg_n);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_q <= '0;
      cnt_q <= 8'h00;
    end else if (a_rate) begin
      sum_q <= (DW+7)'(accel_in);
      cnt_q <= 8'h01;
    end else if (base_rate && a_us && cnt_q < avg_n) begin
      sum_q <= sum_q + (DW+7)'(accel_in);
      cnt_q <= cnt_q + 8'h01;
    end else if (base_rate && cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accel_out <= '0;
    end else if (acc_upd) begin
      // Mean by shift; count is a power of two so no divider is needed
      accel_out <= a_us ? DW'(sum_q >>> a_bwp) : accel_in;
    end
  end

  // Shift taken from the update cycle; a config write may land on that edge
  chk_average_out: assert property (acc_upd && a_us |=>
    accel_out == DW'($past(sum_q) >>> $past(a_bwp)))
    else $error("undersampled output not mean");

  ////////////////////////////////////////////////////////////////////////////
  // Gyroscope path and data-ready strobe
  assign gyr_upd = g_rate && gyro_normal_pm;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gyro_out <= '0;
    end else if (gyr_upd) begin
      gyro_out <= gyro_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      new_sample_signal <= 1'b0;
    end else begin
      new_sample_signal <= acc_upd || gyr_upd;
    end
  end

  sequence s_gyro_update;
    gyr_upd ##1 new_sample_signal;
  endsequence
  chk_gyro_power: assert property (!gyro_normal_pm |-> !gyr_upd)
    else $error("gyro processed outside normal power");
  chk_gyro_ready: assert property (gyr_upd |-> s_gyro_update)
    else $error("gyro update without data-ready");
  chk_update_on_tick: assert property (new_sample_signal |-> $past(tick))
    else $error("data update off time base");

endmodule

// ==== ifc_filter_cfg_test.sv ====
// Purpose: Self-checking bench for the filter and rate configuration block
// Assumes: AXI4-Lite master tasks; short sensor time tick for run length
// Notes: Ready and valid are sampled mid-cycle to avoid edge races
`timescale 1ns/100ps
module ifc_filter_cfg_test;
  import ifc_pkg::*;
  localparam int TICK = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gyro_normal_pm = 1'b1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic signed [15:0] accel_in = '0, gyro_in = '0, accel_out, gyro_out;
  logic new_sample_signal, accel_suspend_phase, accel_prefilt_sel;
  ifc_fmode_t accel_mode, gyro_mode;
  logic [ST_WIDTH-1:0] sensor_time, st_v;
  logic [7:0] fq [3] = '{8'h00, 8'h80, 8'h80};
  logic [15:0] iq [3] = '{16'h0000, 16'h0008, 16'h0080};
  int n_errors = 0, n_compared = 0, cnt;
  always #2 aclk = ~aclk;
  ifc_filter_cfg #(.TICK_CYCLES(TICK), .DW(16)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .accel_in(accel_in),
    .gyro_in(gyro_in), .gyro_normal_pm(gyro_normal_pm), .accel_out(accel_out),
    .gyro_out(gyro_out), .new_sample_signal(new_sample_signal), .accel_mode(accel_mode),
    .gyro_mode(gyro_mode), .accel_suspend_phase(accel_suspend_phase),
    .accel_prefilt_sel(accel_prefilt_sel), .sensor_time(sensor_time));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timeout(input string what);
    n_errors++;
    $display("[FAIL] %s expected answer seen none", what);
    close_out();
  endtask
  // Master releases each channel only at the edge that takes it
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
    if (!hb) timeout("write");
  endtask
  task automatic rd(input logic [7:0] idx);
    logic ha, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hb = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hb) s_axi_rready <= 1'b0;
    end
    if (!hb) timeout("read");
  endtask
  // Error flags lag the config by a cycle; the read is later anyway
  task automatic err_bit(input string what, input int b, input logic e);
    rd(IDX_ERR);
    check(what, {31'h0, rdat[b]}, {31'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_ACC);
    check("accel cfg reset", rdat, {24'h0, RST_ACC});
    rd(IDX_GYR);
    check("rotation cfg reset", rdat, {24'h0, RST_GYR});
    rd(IDX_FIFO);
    check("queue cfg reset", rdat, {24'h0, RST_FIFO});
    rd(IDX_INTD);
    check("int source reset", rdat, {16'h0, RST_INTD});
    rd(IDX_ERR);
    check("error reset", rdat, 32'h0000_0000);
    rd(IDX_TIME);
    check("time read resp", {30'h0, resp}, 32'h0000_0000);
    wr(IDX_ERR, 32'h0000_00ff);
    check("error write resp", {30'h0, resp}, 32'h0000_0002);
    rd(8'hff);
    check("unmapped read resp", {30'h0, resp}, 32'h0000_0002);
    $display("test registers done");
    for (int b = 0; b < 3; b++) begin
      wr(IDX_ACC, {24'h0, 1'b0, 3'(b), 4'h8});
      check("accel mode", {30'h0, accel_mode}, b);
      wr(IDX_GYR, {24'h0, 2'b00, 2'(b), 4'h8});
      check("rotation mode", {30'h0, gyro_mode}, b);
    end
    wr(IDX_ACC, 32'h0000_0088);
    check("accel write resp", {30'h0, resp}, 32'h0000_0000);
    check("accel undersample mode", {30'h0, accel_mode}, 32'h0000_0003);
    $display("test modes done");
    for (int o = 0; o < 16; o++) begin
      wr(IDX_ACC, {24'h0, 4'h2, 4'(o)});
      err_bit("accel rate normal", E_ACC, o < 5 || o > 12);
      wr(IDX_ACC, {24'h0, 4'h8, 4'(o)});
      err_bit("accel rate undersampled", E_ACC, o < 1 || o > 12);
      wr(IDX_GYR, {24'h0, 4'h2, 4'(o)});
      err_bit("rotation rate", E_GYR, o < 6 || o > 13);
    end
    wr(IDX_ACC, 32'h0000_009c);
    err_bit("average overrun", E_AVG, 1'b1);
    wr(IDX_ACC, 32'h0000_009b);
    err_bit("average fits", E_AVG, 1'b0);
    $display("test rates done");
    wr(IDX_ACC, 32'h0000_0088);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_FIFO, {24'h0, fq[i]});
      wr(IDX_INTD, {16'h0, iq[i]});
      check("prefilter select", {31'h0, accel_prefilt_sel}, 32'h0000_0001);
      err_bit("prefilter undersample", E_PREF, 1'b1);
    end
    wr(IDX_INTD, 32'h0000_0000);
    wr(IDX_FIFO, 32'h0000_0080);
    check("filtered select", {31'h0, accel_prefilt_sel}, 32'h0000_0000);
    err_bit("filtered undersample", E_PREF, 1'b0);
    wr(IDX_ACC, 32'h0000_0028);
    wr(IDX_FIFO, 32'h0000_0000);
    err_bit("prefilter normal power", E_PREF, 1'b0);
    wr(IDX_FIFO, 32'h0000_0080);
    $display("test prefilter done");
    @(negedge aclk);
    st_v = sensor_time;
    for (int n = 0; n < 2 * TICK && sensor_time === st_v; n++) @(negedge aclk);
    st_v = sensor_time;
    repeat (5 * TICK) @(negedge aclk);
    check("sensor time", {8'h0, sensor_time}, {8'h0, st_v + 24'd5});
    $display("test sensor time done");
    wr(IDX_ACC, 32'h0000_002c);
    wr(IDX_GYR, 32'h0000_002d);
    accel_in <= 16'sd100;
    gyro_in <= 16'sd200;
    cnt = 0;
    @(negedge aclk);
    while (new_sample_signal !== 1'b1) begin
      @(negedge aclk);
      cnt++;
      if (cnt > 400) timeout("sample strobe");
    end
    @(negedge aclk);
    check("strobe width", {31'h0, new_sample_signal}, 32'h0000_0000);
    repeat (400) @(negedge aclk);
    check("accel out", accel_out, 32'd100);
    check("rotation out", gyro_out, 32'd200);
    @(posedge aclk);
    gyro_normal_pm <= 1'b0;
    gyro_in <= 16'sd300;
    accel_in <= 16'sd300;
    repeat (400) @(negedge aclk);
    check("rotation held", gyro_out, 32'd200);
    check("accel follows", accel_out, 32'd300);
    // Constant input: a missing shift doubles the result
    wr(IDX_ACC, 32'h0000_009a);
    accel_in <= 16'sd40;
    cnt = 0;
    repeat (1600) begin
      @(negedge aclk);
      if (accel_suspend_phase === 1'b1) cnt++;
    end
    check("suspend phase seen", {31'h0, cnt > 0}, 32'h0000_0001);
    check("averaged out", accel_out, 32'd40);
    $display("test samples done");
    close_out();
  end
endmodule

// ==== ifc_pkg.sv ====
// Purpose: Constants for the accel/gyro filter and rate configuration block
// Assumes: 250 MHz aclk, AXI4-Lite register access, one word per register
// Notes: Register offsets are indices; byte address is four times the index
package ifc_pkg;
  // Register indices
  localparam logic [7:0] IDX_ERR = 8'h02;
  localparam logic [7:0] IDX_ACC = 8'h40;
  localparam logic [7:0] IDX_GYR = 8'h41;
  localparam logic [7:0] IDX_FIFO = 8'h45;
  localparam logic [7:0] IDX_INTD = 8'h58;
  localparam logic [7:0] IDX_TIME = 8'h18;
  // Reset values
  localparam logic [7:0] RST_ACC = 8'h28;
  localparam logic [7:0] RST_GYR = 8'h28;
  localparam logic [7:0] RST_FIFO = 8'h80;
  localparam logic [15:0] RST_INTD = 16'h0000;
  // Field positions
  localparam int F_ODR_LSB = 0;
  localparam int F_BWP_LSB = 4;
  localparam int F_US = 7;
  localparam int F_FIFO_FILT = 7;
  localparam int F_TAP_SRC = 3;
  localparam int F_MOT_SRC = 7;
  // Error bits
  localparam int E_ACC = 0;
  localparam int E_GYR = 1;
  localparam int E_PREF = 2;
  localparam int E_AVG = 3;
  // Rate codes: bit m of sensor time toggles at rate code c, m = 16 - c
  localparam logic [3:0] ACC_ODR_MIN_NORM = 4'h5;
  localparam logic [3:0] ACC_ODR_MIN_US = 4'h1;
  localparam logic [3:0] ACC_ODR_MAX = 4'hc;
  localparam logic [3:0] GYR_ODR_MIN = 4'h6;
  localparam logic [3:0] GYR_ODR_MAX = 4'hd;
  localparam int ODR_BIT_BASE = 16;
  localparam int BASE_RATE_BIT = 4;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int ST_TICK_US = 39;
  localparam int ST_TICK_CYC = (ST_TICK_US * 1000) / CLK_PERIOD_NS;
  localparam int ST_WIDTH = 24;
  typedef enum logic [1:0] {
    FM_OVERSAMPLE_BY_FOUR = 2'b00,
    FM_OVERSAMPLE_BY_TWO = 2'b01,
    FM_NORMAL = 2'b10,
    FM_UNDERSAMPLE = 2'b11
  } ifc_fmode_t;
endpackage
